// *** rtl/aipc_regs.sv ***
// program id, minor revision and power and boot control registers
//
// Functional notes
// - program code reads 0x03 app, 0x80 bootloader
// - minor revision byte at 0x01, resets zero
// - below 0xE0 unusable until cpu ready
// - cpu ready read-only, reset zero, firmware-set
// - boot choice bits 5:4, reset zero
// - boot choice kept in always-on domain
// - boot choice drives no hardware directly
// - oscillator request 0 to 1 starts oscillator
// - writing zero interrupts processor for shutdown
// - firmware powers down modules before standby
// - application registers only while code is 0x03
`timescale 1ns/1ps
`default_nettype none
module aipc_regs
(
    input wire logic mclk,
    input wire logic rstn,
    input wire logic aon_rstn,
    input wire aipc_pkg::aipc_host_req_type host_req,
    output logic [7:0] host_rdata,
    output logic host_rvalid,
    output logic host_blocked,
    input wire aipc_pkg::aipc_fw_req_type fw_req,
    input wire logic fw_osc_off,
    output logic osc_enable,
    output logic wake_interrupt,
    output logic standby_interrupt,
    output logic [1:0] boot_choice,
    output logic app_regs_enable
);
    // ----------------------------------------------------------------
    // main domain state
    // ----------------------------------------------------------------
    logic [7:0] code_q, code_d;
    logic [7:0] minor_q, minor_d;
    logic ready_q, ready_d;
    logic osc_req_q, osc_req_d;
    logic osc_q, osc_d;
    logic wake_q, wake_d;
    logic stby_q, stby_d;
    logic [7:0] rdata_q, rdata_d;
    logic rvalid_q, rvalid_d;
    logic blocked_q, blocked_d;
    logic [1:0] boot_q, boot_d;

    // address below the always-usable window
    function automatic logic is_gated(input logic [7:0] a);
        return a < aipc_pkg::OFS_GATED_LIMIT;
    endfunction

    // control register write strobe, shared by both state groups
    logic wr_ctrl;
    logic access_ok;
    // nothing below the gate is writable here, so a gated write only flags
    assign access_ok = ready_q || !is_gated(host_req.addr);
    assign wr_ctrl = host_req.wr && (host_req.addr == aipc_pkg::OFS_POWER_CTRL);

    // next-state for program id, ready flag and oscillator control
    always_comb
    begin
        code_d = code_q;
        minor_d = minor_q;
        ready_d = ready_q;
        osc_req_d = osc_req_q;
        osc_d = osc_q;
        wake_d = 1'b0;
        stby_d = 1'b0;
        // host writes to 0x00/0x01 have no path here
        if (fw_req.set_code)
            code_d = fw_req.code;
        if (fw_req.set_minor)
            minor_d = fw_req.minor;
        // only firmware moves the ready flag
        // set wins over clear when both come in one cycle
        if (fw_req.clr_ready)
            ready_d = 1'b0;
        if (fw_req.set_ready)
            ready_d = 1'b1;
        // firmware stops the clock only after its own power down
        if (fw_osc_off)
            osc_d = 1'b0;
        // a wake write in the same cycle wins over the firmware stop
        // the request bit follows the host; the clock only follows a 0 to 1 step
        if (wr_ctrl)
        begin
            osc_req_d = host_req.wdata[aipc_pkg::BIT_OSC_ON];
            if (!osc_req_q && host_req.wdata[aipc_pkg::BIT_OSC_ON])
            begin
                osc_d = 1'b1;
                wake_d = 1'b1;
            end
            else if (!host_req.wdata[aipc_pkg::BIT_OSC_ON])
                stby_d = 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            code_q <= aipc_pkg::RST_PROGRAM_CODE;
            minor_q <= aipc_pkg::RST_MINOR_REV;
            ready_q <= aipc_pkg::RST_CPU_READY;
            osc_req_q <= aipc_pkg::RST_OSC_ON;
            osc_q <= aipc_pkg::RST_OSC_ON;
            wake_q <= 1'b0;
            stby_q <= 1'b0;
        end
        else
        begin
            code_q <= code_d;
            minor_q <= minor_d;
            ready_q <= ready_d;
            osc_req_q <= osc_req_d;
            osc_q <= osc_d;
            wake_q <= wake_d;
            stby_q <= stby_d;
        end
    end

    // ----------------------------------------------------------------
    // always-on boot choice
    // ----------------------------------------------------------------
    // own reset so standby leaves it alone
    // the reserved value is stored as written; keeping clear of it is the host's duty
    always_comb
    begin
        boot_d = boot_q;
        if (wr_ctrl)
            boot_d = host_req.wdata[aipc_pkg::BIT_BOOT_HI:aipc_pkg::BIT_BOOT_LO];
    end

    always_ff @(posedge mclk or negedge aon_rstn)
    begin
        if (!aon_rstn)
            boot_q <= aipc_pkg::RST_BOOT_CHOICE;
        else
            boot_q <= boot_d;
    end

    // ----------------------------------------------------------------
    // read path
    // ----------------------------------------------------------------
    // gated reads return zero and raise blocked for one cycle
    // rvalid follows the read strobe alone, so a blocked read still answers
    always_comb
    begin
        rdata_d = 8'h00;
        rvalid_d = host_req.rd;
        blocked_d = (host_req.rd || host_req.wr) && !access_ok;
        if (host_req.rd && access_ok)
        begin
            case (host_req.addr)
                aipc_pkg::OFS_PROGRAM_CODE: rdata_d = code_q;
                aipc_pkg::OFS_MINOR_REV: rdata_d = minor_q;
                aipc_pkg::OFS_POWER_CTRL:
                begin
                    rdata_d[aipc_pkg::BIT_CPU_READY] = ready_q;
                    rdata_d[aipc_pkg::BIT_BOOT_HI:aipc_pkg::BIT_BOOT_LO] = boot_q;
                    rdata_d[aipc_pkg::BIT_OSC_ON] = osc_req_q;
                end
                default: rdata_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            rdata_q <= 8'h00;
            rvalid_q <= 1'b0;
            blocked_q <= 1'b0;
        end
        else
        begin
            rdata_q <= rdata_d;
            rvalid_q <= rvalid_d;
            blocked_q <= blocked_d;
        end
    end

    // ----------------------------------------------------------------
    // application register window
    // ----------------------------------------------------------------
    // registered, so the enable cannot glitch while the code changes
    logic app_q, app_d;

    always_comb
    begin
        app_d = (code_d == aipc_pkg::CODE_MEASURE_APP);
    end

    // reset value follows from the reset value of the program code
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            app_q <= (aipc_pkg::RST_PROGRAM_CODE == aipc_pkg::CODE_MEASURE_APP);
        else
            app_q <= app_d;
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign host_rdata = rdata_q;
    assign host_rvalid = rvalid_q;
    assign host_blocked = blocked_q;
    assign osc_enable = osc_q;
    // the pulses last one cycle; the processor side must latch them
    assign wake_interrupt = wake_q;
    assign standby_interrupt = stby_q;
    // firmware reads this; no circuit acts on it
    assign boot_choice = boot_q;
    assign app_regs_enable = app_q;
endmodule // aipc_regs
`default_nettype wire

// *** shared/aipc_pkg.sv ***
// package: offsets, fields, reset values and encodings of the program id and power control registers
`default_nettype none
package aipc_pkg;
    // register offsets
    localparam logic [7:0] OFS_PROGRAM_CODE = 8'h00;
    localparam logic [7:0] OFS_MINOR_REV = 8'h01;
    localparam logic [7:0] OFS_POWER_CTRL = 8'hE0;
    localparam logic [7:0] OFS_GATED_LIMIT = 8'hE0;
    // running program codes
    localparam logic [7:0] CODE_MEASURE_APP = 8'h03;
    localparam logic [7:0] CODE_BOOTLOADER = 8'h80;
    // control register fields
    localparam int BIT_OSC_ON = 0;
    localparam int BIT_BOOT_LO = 4;
    localparam int BIT_BOOT_HI = 5;
    localparam int BIT_CPU_READY = 6;
    // reset values
    localparam logic [7:0] RST_PROGRAM_CODE = 8'h00;
    localparam logic [7:0] RST_MINOR_REV = 8'h00;
    localparam logic RST_OSC_ON = 1'b1;
    localparam logic [1:0] RST_BOOT_CHOICE = 2'h0;
    localparam logic RST_CPU_READY = 1'b0;
    // remap settle time, kept for the host side
    localparam int REMAP_SETTLE_MS = 6;
    localparam int CLK_HZ = 10_000_000;
    localparam int REMAP_SETTLE_CYCLES = REMAP_SETTLE_MS * (CLK_HZ / 1000);

    typedef enum logic [1:0]
    {
        BOOT_LOADER = 2'h0,
        BOOT_LOADER_AWAKE = 2'h1,
        BOOT_RAM_APP = 2'h2,
        BOOT_RESERVED = 2'h3
    } aipc_boot_type;

    // host register access, one byte at a time
    typedef struct packed
    {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } aipc_host_req_type;

    // firmware side status inputs
    typedef struct packed
    {
        logic set_code;
        logic [7:0] code;
        logic set_minor;
        logic [7:0] minor;
        logic set_ready;
        logic clr_ready;
    } aipc_fw_req_type;
endpackage
`default_nettype wire

// *** verification/aipc_fw_model.sv ***
// firmware stand-in behind the register block
`timescale 1ns/1ps
`default_nettype none
module aipc_fw_model
(
    input wire logic mclk,
    input wire logic standby_interrupt,
    output var aipc_pkg::aipc_fw_req_type fw_req,
    output var logic fw_osc_off
);
    // modules go down first, so the oscillator stops late
    initial
    begin
        fw_req = '0;
        fw_osc_off = 1'b0;
        forever
        begin
            @(posedge standby_interrupt);
            repeat (5) @(negedge mclk);
            fw_osc_off = 1'b1;
            @(negedge mclk);
            fw_osc_off = 1'b0;
        end
    end
    // one-cycle load of code, minor and ready
    task automatic load(input logic [7:0] c, input logic [7:0] m);
        @(negedge mclk);
        fw_req = '{1'b1, c, 1'b1, m, 1'b1, 1'b0};
        @(negedge mclk);
        fw_req = '0;
    endtask
endmodule // aipc_fw_model
`default_nettype wire

// *** verification/aipc_regs_properties.sv ***
// port assertions of the program id and power control registers
`timescale 1ns/1ps
`default_nettype none
module aipc_regs_properties
(
    input wire logic mclk,
    input wire logic rstn,
    input wire aipc_pkg::aipc_host_req_type host_req,
    input wire logic [7:0] host_rdata,
    input wire logic host_rvalid,
    input wire logic host_blocked,
    input wire logic fw_osc_off,
    input wire logic osc_enable,
    input wire logic wake_interrupt,
    input wire logic standby_interrupt,
    input wire logic [1:0] boot_choice
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);
    // host write aimed at the control register
    wire logic ctrl_w = host_req.wr && host_req.addr == aipc_pkg::OFS_POWER_CTRL;
    sequence clr_req; ctrl_w && !host_req.wdata[0]; endsequence
    a_wake_cause: assert property (wake_interrupt |-> $past(ctrl_w && host_req.wdata[0]) && osc_enable)
        else $error("wake pulse without set write");
    a_wake_single: assert property (wake_interrupt |=> !wake_interrupt)
        else $error("wake pulse too long");
    a_standby_req: assert property (clr_req |=> standby_interrupt)
        else $error("no standby pulse");
    a_standby_cause: assert property (standby_interrupt |-> $past(ctrl_w) && !$past(host_req.wdata[0]))
        else $error("stray standby pulse");
    a_osc_fw_stop: assert property ($fell(osc_enable) |-> $past(fw_osc_off))
        else $error("oscillator stopped by host");
    a_blocked_low: assert property (host_blocked |-> $past(host_req.addr < 8'hE0 && (host_req.rd || host_req.wr)))
        else $error("block above gate");
    a_ctrl_unused: assert property ($past(host_req.rd && host_req.addr == 8'hE0) |-> !host_rdata[7] && host_rdata[3:1] == 3'h0)
        else $error("unused bits set");
    a_boot_hold: assert property (!$past(ctrl_w) |-> $stable(boot_choice))
        else $error("boot choice moved");
endmodule // aipc_regs_properties
bind aipc_regs aipc_regs_properties u_props (.mclk, .rstn, .host_req, .host_rdata, .host_rvalid,
    .host_blocked, .fw_osc_off, .osc_enable, .wake_interrupt, .standby_interrupt, .boot_choice);
`default_nettype wire

// *** verification/app_id_and_power_control_regs_tb.sv ***
// testbench: host accesses and checks of the register block
`timescale 1ns/1ps
`default_nettype none
module app_id_and_power_control_regs_tb;
    logic mclk = 1'b0;
    logic rstn = 1'b0;
    logic aon_rstn = 1'b0;
    aipc_pkg::aipc_host_req_type host_req = '0;
    aipc_pkg::aipc_fw_req_type fw_req;
    logic [7:0] host_rdata;
    logic host_rvalid, host_blocked, fw_osc_off, osc_enable, wake_interrupt, standby_interrupt, app_regs_enable;
    logic [1:0] boot_choice;
    int fails = 0;
    int total_checks = 0;
    always #50 mclk = ~mclk;
    aipc_regs DUT (.mclk, .rstn, .aon_rstn, .host_req, .host_rdata, .host_rvalid, .host_blocked, .fw_req,
        .fw_osc_off, .osc_enable, .wake_interrupt, .standby_interrupt, .boot_choice, .app_regs_enable);
    aipc_fw_model fw (.mclk, .standby_interrupt, .fw_req, .fw_osc_off);
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // idle cycle after each access keeps one assignment per time step
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic ew, input logic es);
        host_req = '{1'b1, 1'b0, a, d};
        @(negedge mclk);
        chk({6'h0, wake_interrupt, standby_interrupt}, {6'h0, ew, es});
        host_req = '0;
        @(negedge mclk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic blk);
        host_req = '{1'b0, 1'b1, a, 8'h00};
        @(negedge mclk);
        chk(host_rdata, exp);
        chk({7'h0, host_blocked}, {7'h0, blk});
        chk({7'h0, host_rvalid}, 8'h01);
        host_req = '0;
        @(negedge mclk);
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // watchdog: the settle wait plus 2000 cycles, far above the about 70 access cycles
    initial
    begin
        #((aipc_pkg::REMAP_SETTLE_CYCLES + 2000) * 100);
        fails++;
        $display("Error at %0t: watchdog expired", $time);
        wrap_up;
    end
    initial
    begin
        repeat (20) @(negedge mclk);
        rstn = 1'b1;
        aon_rstn = 1'b1;
        rd(8'hE0, 8'h01, 1'b0);
        rd(8'h00, 8'h00, 1'b1);
        wr(8'hE0, 8'h20, 1'b0, 1'b1);
        chk({7'h0, osc_enable}, 8'h01);
        repeat (10) @(negedge mclk);
        chk({7'h0, osc_enable}, 8'h00);
        wr(8'hE0, 8'h21, 1'b1, 1'b0);
        chk({7'h0, osc_enable}, 8'h01);
        wr(8'hE0, 8'hEF, 1'b0, 1'b0);
        rd(8'hE0, 8'h21, 1'b0);
        // boot values 0 to 2 only; 3 is reserved
        for (int b = 0; b < 3; b++)
        begin
            wr(8'hE0, {2'b00, b[1:0], 4'h1}, 1'b0, 1'b0);
            chk({6'h0, boot_choice}, {6'h0, b[1:0]});
        end
        rstn = 1'b0;
        @(negedge mclk);
        rstn = 1'b1;
        rd(8'hE0, 8'h21, 1'b0);
        $display("power test done");
        fw.load(8'h03, 8'h05);
        // the code and revision are read only after the settle time
        repeat (aipc_pkg::REMAP_SETTLE_CYCLES) @(negedge mclk);
        rd(8'h00, 8'h03, 1'b0);
        rd(8'h01, 8'h05, 1'b0);
        rd(8'hE0, 8'h61, 1'b0);
        chk({7'h0, app_regs_enable}, 8'h01);
        wr(8'h00, 8'h80, 1'b0, 1'b0);
        rd(8'h00, 8'h03, 1'b0);
        rd(8'h10, 8'h00, 1'b0);
        fw.load(8'h80, 8'h02);
        rd(8'h00, 8'h80, 1'b0);
        chk({7'h0, app_regs_enable}, 8'h00);
        $display("program test done");
        wrap_up;
    end
endmodule // app_id_and_power_control_regs_tb
`default_nettype wire
